/* File: rtl/bgp_pkg.sv */
// Constants, field layouts and carrier types of the backup pin unit.
// Assumes a single 200 MHz core clock and a 32.768 kHz reference pin.
`default_nettype none

package bgp_pkg;

  // Pin counts
  localparam int N_OUT = 4;
  localparam int N_BIDIR = 7;
  localparam int N_PIN = 11;
  localparam int AUX_IDX = 2;

  // Register byte offsets
  localparam logic [7:0] OFF_DIR = 8'h00;
  localparam logic [7:0] OFF_OUT = 8'h04;
  localparam logic [7:0] OFF_IN = 8'h08;
  localparam logic [7:0] OFF_RISE_EN = 8'h0c;
  localparam logic [7:0] OFF_FALL_EN = 8'h10;
  localparam logic [7:0] OFF_RISE_FLG = 8'h14;
  localparam logic [7:0] OFF_FALL_FLG = 8'h18;
  localparam logic [7:0] OFF_FUNC = 8'h1c;
  localparam logic [7:0] OFF_CLKDIV = 8'h20;
  localparam logic [7:0] OFF_IRQ_EN0 = 8'h24;
  localparam logic [7:0] OFF_IRQ_EN1 = 8'h28;
  localparam logic [7:0] OFF_IRQ_FLG0 = 8'h2c;
  localparam logic [7:0] OFF_IRQ_FLG1 = 8'h30;

  // Reset values
  localparam logic [6:0] DIR_RST = 7'h7f;
  localparam logic [10:0] OUT_RST = 11'h000;
  localparam logic [12:0] CLKDIV_RST = 13'h0001;

  // Divider and PWM figures
  localparam int DIV_WIDTH = 13;
  localparam logic [12:0] DIV_MAX = 13'h1000;
  localparam int PWM_EXP_BASE = 4;
  localparam logic [15:0] PWM_IDLE_CNT = 16'hffff;

  // Pin-two function select codes
  localparam logic [1:0] SEL_GPIO = 2'h0;
  localparam logic [1:0] SEL_CLK = 2'h1;
  localparam logic [1:0] SEL_PWM = 2'h2;

  // Pin function register layout
  typedef struct packed {
    logic [15:0] period;
    logic [8:0] rsv_hi;
    logic [2:0] wexp;
    logic [1:0] rsv_lo;
    logic [1:0] sel;
  } bgp_func_t;

  // PWM phase
  typedef enum logic {PWM_LOW = 1'b0, PWM_HIGH = 1'b1} bgp_pwm_st_t;

endpackage

`default_nettype wire

/* File: rtl/bgp_periph_div.sv */
// Reference synchroniser and peripheral tick divider.
// Assumes the 32.768 kHz reference is asynchronous to the core clock.
`default_nettype none

module bgp_periph_div
  import bgp_pkg::*;
#(
  parameter int DIV_W = DIV_WIDTH
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Reference and divide value
  input wire logic ref_32k_i,
  input wire logic [DIV_W-1:0] div_val_i,
  // Outputs
  output logic clk32_lvl_o,
  output logic periph_tick_o
);

  // Divide value must reach 4096
  if (DIV_W < DIV_WIDTH)
  begin : g_chk
    $error("bgp_periph_div: DIV_W too small");
  end

  logic ref_s1_ff, ref_s2_ff, ref_s3_ff;
  logic [DIV_W-1:0] cnt_ff, nxt_cnt;
  logic tick_ff, nxt_tick;
  logic [DIV_W-1:0] div_eff;
  logic ref_rise;

  // Clamp divide value into 1..4096
  assign div_eff = (div_val_i == '0) ? DIV_W'(1) :
                   (div_val_i > DIV_W'(DIV_MAX)) ? DIV_W'(DIV_MAX) : div_val_i;
  assign ref_rise = ref_s2_ff & ~ref_s3_ff;

  // Count reference edges, one tick per divide value
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (ref_rise)
    begin
      if (cnt_ff >= div_eff - DIV_W'(1))
      begin
        nxt_cnt = '0;
        nxt_tick = 1'b1;
      end
      else
      begin
        nxt_cnt = cnt_ff + DIV_W'(1);
      end
    end
  end

  // Registers
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ref_s1_ff <= 1'b0;
      ref_s2_ff <= 1'b0;
      ref_s3_ff <= 1'b0;
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      ref_s1_ff <= ref_32k_i;
      ref_s2_ff <= ref_s1_ff;
      ref_s3_ff <= ref_s2_ff;
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign clk32_lvl_o = ref_s2_ff;
  assign periph_tick_o = tick_ff;

  // Tick only after a reference edge
  chk_tick_cause: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    periph_tick_o |-> $past(ref_rise))
    else $error("peripheral tick without reference edge");

endmodule

`default_nettype wire

/* File: rtl/bgp_unit.sv */
// Backup pin unit: direction, drive, filtered sampling, edge flags, pin-two clock or PWM,
// interrupt combiner, reached as an AHB-Lite slave.
// Assumes calendar and host events are one-cycle pulses in the core clock domain.
`default_nettype none

module bgp_unit
  import bgp_pkg::*;
#(
  parameter logic [N_BIDIR-1:0] OD_MASK = 7'h00
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Reference clock pin
  input wire logic ref_32k_i,
  // Pins
  output logic [N_OUT-1:0] output_only_pin_o,
  input wire logic [N_BIDIR-1:0] bidir_pin_i,
  output logic [N_BIDIR-1:0] bidir_pin_o,
  output logic [N_BIDIR-1:0] bidir_pin_oe_o,
  // Combiner sources and output
  input wire logic [6:0] host_evt_i,
  input wire logic [7:0] cal_evt_i,
  output logic combined_irq_out_o
);

  // Bus data phase state
  logic dp_valid_ff, nxt_dp_valid;
  logic dp_write_ff, nxt_dp_write;
  logic [7:0] dp_addr_ff, nxt_dp_addr;
  logic wr_en;

  // Software registers
  logic [N_BIDIR-1:0] dir_ff, nxt_dir;
  logic [N_PIN-1:0] out_ff, nxt_out;
  logic [N_BIDIR-1:0] rise_en_ff, nxt_rise_en;
  logic [N_BIDIR-1:0] fall_en_ff, nxt_fall_en;
  logic [N_BIDIR-1:0] rise_flg_ff, nxt_rise_flg;
  logic [N_BIDIR-1:0] fall_flg_ff, nxt_fall_flg;
  bgp_func_t func_ff, nxt_func;
  logic [DIV_WIDTH-1:0] clkdiv_ff, nxt_clkdiv;
  logic [7:0] irq_en0_ff, nxt_irq_en0;
  logic [7:0] irq_en1_ff, nxt_irq_en1;
  logic [7:0] irq_flg0_ff, nxt_irq_flg0;
  logic [7:0] irq_flg1_ff, nxt_irq_flg1;

  // Input path state
  logic [N_BIDIR-1:0] pin_s1_ff, pin_s2_ff;
  logic [N_BIDIR-1:0] samp_ff, nxt_samp;
  logic [N_BIDIR-1:0] filt_ff, nxt_filt;
  logic [N_BIDIR-1:0] rise_evt, fall_evt;
  logic pin_irq;

  // PWM state
  logic [15:0] pwm_cnt_ff, nxt_pwm_cnt;
  bgp_pwm_st_t pwm_st_ff, nxt_pwm_st;
  logic [15:0] pwm_width;

  // Pin drive state
  logic [N_OUT-1:0] oo_drv_ff, nxt_oo_drv;
  logic [N_BIDIR-1:0] bd_o_ff, nxt_bd_o;
  logic [N_BIDIR-1:0] bd_oe_ff, nxt_bd_oe;

  // Divider outputs
  logic clk32_lvl;
  logic periph_tick;

  // Write strobe decode for one register
  function automatic logic reg_wr(input logic en, input logic [7:0] addr, input logic [7:0] off);
    reg_wr = en && (addr == off);
  endfunction

  // Peripheral clock divider
  bgp_periph_div #(
    .DIV_W(DIV_WIDTH)
  ) u_div (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .ref_32k_i(ref_32k_i),
    .div_val_i(clkdiv_ff),
    .clk32_lvl_o(clk32_lvl),
    .periph_tick_o(periph_tick)
  );

  // Bus address phase capture; always ready, always OKAY
  always_comb
  begin
    nxt_dp_valid = hsel_i && hready_i && htrans_i[1];
    nxt_dp_write = hwrite_i;
    nxt_dp_addr = {haddr_i[7:2], 2'b00};
  end

  assign wr_en = dp_valid_ff && dp_write_ff;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dp_valid_ff <= 1'b0;
      dp_write_ff <= 1'b0;
      dp_addr_ff <= 8'h00;
    end
    else
    begin
      dp_valid_ff <= nxt_dp_valid;
      dp_write_ff <= nxt_dp_write;
      dp_addr_ff <= nxt_dp_addr;
    end
  end

  // Input synchroniser, anti-chatter filter and edge detect
  always_comb
  begin
    nxt_samp = samp_ff;
    nxt_filt = filt_ff;
    if (periph_tick)
    begin
      nxt_samp = pin_s2_ff;
      nxt_filt = (pin_s2_ff & ~(pin_s2_ff ^ samp_ff)) | (filt_ff & (pin_s2_ff ^ samp_ff));
    end
    rise_evt = dir_ff & nxt_filt & ~filt_ff;
    fall_evt = dir_ff & ~nxt_filt & filt_ff;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      samp_ff <= '0;
      filt_ff <= '0;
    end
    else
    begin
      pin_s1_ff <= bidir_pin_i;
      pin_s2_ff <= pin_s1_ff;
      samp_ff <= nxt_samp;
      filt_ff <= nxt_filt;
    end
  end

  // Pin interrupt from enabled pending flags
  assign pin_irq = |((rise_flg_ff & rise_en_ff) | (fall_flg_ff & fall_en_ff));

  // Register writes; hardware set wins over write-one clear
  always_comb
  begin
    nxt_dir = dir_ff;
    nxt_out = out_ff;
    nxt_rise_en = rise_en_ff;
    nxt_fall_en = fall_en_ff;
    nxt_func = func_ff;
    nxt_clkdiv = clkdiv_ff;
    nxt_irq_en0 = irq_en0_ff;
    nxt_irq_en1 = irq_en1_ff;
    nxt_rise_flg = rise_flg_ff;
    nxt_fall_flg = fall_flg_ff;
    nxt_irq_flg0 = irq_flg0_ff;
    nxt_irq_flg1 = irq_flg1_ff;
    if (reg_wr(wr_en, dp_addr_ff, OFF_DIR))
      nxt_dir = hwdata_i[N_BIDIR-1:0];
    if (reg_wr(wr_en, dp_addr_ff, OFF_OUT))
      nxt_out = hwdata_i[N_PIN-1:0];
    if (reg_wr(wr_en, dp_addr_ff, OFF_RISE_EN))
      nxt_rise_en = hwdata_i[N_BIDIR-1:0];
    if (reg_wr(wr_en, dp_addr_ff, OFF_FALL_EN))
      nxt_fall_en = hwdata_i[N_BIDIR-1:0];
    if (reg_wr(wr_en, dp_addr_ff, OFF_FUNC))
    begin
      nxt_func = bgp_func_t'(hwdata_i);
      nxt_func.rsv_hi = '0;
      nxt_func.rsv_lo = '0;
    end
    if (reg_wr(wr_en, dp_addr_ff, OFF_CLKDIV))
      nxt_clkdiv = hwdata_i[DIV_WIDTH-1:0];
    if (reg_wr(wr_en, dp_addr_ff, OFF_IRQ_EN0))
      nxt_irq_en0 = hwdata_i[7:0];
    if (reg_wr(wr_en, dp_addr_ff, OFF_IRQ_EN1))
      nxt_irq_en1 = hwdata_i[7:0];
    if (reg_wr(wr_en, dp_addr_ff, OFF_RISE_FLG))
      nxt_rise_flg = rise_flg_ff & ~hwdata_i[N_BIDIR-1:0];
    if (reg_wr(wr_en, dp_addr_ff, OFF_FALL_FLG))
      nxt_fall_flg = fall_flg_ff & ~hwdata_i[N_BIDIR-1:0];
    if (reg_wr(wr_en, dp_addr_ff, OFF_IRQ_FLG0))
      nxt_irq_flg0 = irq_flg0_ff & ~hwdata_i[7:0];
    if (reg_wr(wr_en, dp_addr_ff, OFF_IRQ_FLG1))
      nxt_irq_flg1 = irq_flg1_ff & ~hwdata_i[7:0];
    nxt_rise_flg = nxt_rise_flg | rise_evt;
    nxt_fall_flg = nxt_fall_flg | fall_evt;
    nxt_irq_flg0 = nxt_irq_flg0 | {host_evt_i, pin_irq};
    nxt_irq_flg1 = nxt_irq_flg1 | cal_evt_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dir_ff <= DIR_RST;
      out_ff <= OUT_RST;
      rise_en_ff <= '0;
      fall_en_ff <= '0;
      rise_flg_ff <= '0;
      fall_flg_ff <= '0;
      func_ff <= '0;
      clkdiv_ff <= CLKDIV_RST;
      irq_en0_ff <= 8'h00;
      irq_en1_ff <= 8'h00;
      irq_flg0_ff <= 8'h00;
      irq_flg1_ff <= 8'h00;
    end
    else
    begin
      dir_ff <= nxt_dir;
      out_ff <= nxt_out;
      rise_en_ff <= nxt_rise_en;
      fall_en_ff <= nxt_fall_en;
      rise_flg_ff <= nxt_rise_flg;
      fall_flg_ff <= nxt_fall_flg;
      func_ff <= nxt_func;
      clkdiv_ff <= nxt_clkdiv;
      irq_en0_ff <= nxt_irq_en0;
      irq_en1_ff <= nxt_irq_en1;
      irq_flg0_ff <= nxt_irq_flg0;
      irq_flg1_ff <= nxt_irq_flg1;
    end
  end

  // Combined interrupt line
  assign combined_irq_out_o = |(irq_flg0_ff & irq_en0_ff) | |(irq_flg1_ff & irq_en1_ff);

  // PWM counter stepped on peripheral ticks; phase set each cycle from counter and width
  assign pwm_width = 16'(16'h0001 << ({1'b0, func_ff.wexp} + 4'(PWM_EXP_BASE)));

  always_comb
  begin
    nxt_pwm_cnt = pwm_cnt_ff;
    nxt_pwm_st = pwm_st_ff;
    if (func_ff.sel != SEL_PWM || func_ff.period == 16'h0000)
    begin
      nxt_pwm_cnt = PWM_IDLE_CNT;
      nxt_pwm_st = PWM_LOW;
    end
    else if (periph_tick)
    begin
      if (pwm_cnt_ff >= func_ff.period - 16'h0001)
        nxt_pwm_cnt = 16'h0000;
      else
        nxt_pwm_cnt = pwm_cnt_ff + 16'h0001;
    end
    // Phase follows the live width every cycle, so a narrowed width cuts a high at once
    nxt_pwm_st = (nxt_pwm_cnt < pwm_width) ? PWM_HIGH : PWM_LOW;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pwm_cnt_ff <= PWM_IDLE_CNT;
      pwm_st_ff <= PWM_LOW;
    end
    else
    begin
      pwm_cnt_ff <= nxt_pwm_cnt;
      pwm_st_ff <= nxt_pwm_st;
    end
  end

  // Pin drive: output-only pins, pin-two function, bidirectional pins
  always_comb
  begin
    nxt_oo_drv = out_ff[N_OUT-1:0];
    unique case (func_ff.sel)
      SEL_CLK: nxt_oo_drv[AUX_IDX] = clk32_lvl;
      SEL_PWM:
      begin
        unique case (pwm_st_ff)
          PWM_HIGH: nxt_oo_drv[AUX_IDX] = 1'b1;
          PWM_LOW: nxt_oo_drv[AUX_IDX] = 1'b0;
        endcase
      end
      default: nxt_oo_drv[AUX_IDX] = out_ff[AUX_IDX];
    endcase
    nxt_bd_o = out_ff[N_PIN-1:N_OUT] & ~OD_MASK;
    nxt_bd_oe = ~dir_ff & (~OD_MASK | ~out_ff[N_PIN-1:N_OUT]);
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      oo_drv_ff <= '0;
      bd_o_ff <= '0;
      bd_oe_ff <= '0;
    end
    else
    begin
      oo_drv_ff <= nxt_oo_drv;
      bd_o_ff <= nxt_bd_o;
      bd_oe_ff <= nxt_bd_oe;
    end
  end

  assign output_only_pin_o = oo_drv_ff;
  assign bidir_pin_o = bd_o_ff;
  assign bidir_pin_oe_o = bd_oe_ff;

  // Read mux for the data phase; unmapped reads as zero
  always_comb
  begin
    hrdata_o = 32'h0000_0000;
    if (dp_valid_ff && !dp_write_ff)
    begin
      unique case (dp_addr_ff)
        OFF_DIR: hrdata_o[N_BIDIR-1:0] = dir_ff;
        OFF_OUT: hrdata_o[N_PIN-1:0] = out_ff;
        OFF_IN:
        begin
          hrdata_o[N_OUT-1:0] = oo_drv_ff;
          hrdata_o[N_PIN-1:N_OUT] = (dir_ff & filt_ff) | (~dir_ff & OD_MASK & pin_s2_ff) |
                                     (~dir_ff & ~OD_MASK & out_ff[N_PIN-1:N_OUT]);
        end
        OFF_RISE_EN: hrdata_o[N_BIDIR-1:0] = rise_en_ff;
        OFF_FALL_EN: hrdata_o[N_BIDIR-1:0] = fall_en_ff;
        OFF_RISE_FLG: hrdata_o[N_BIDIR-1:0] = rise_flg_ff;
        OFF_FALL_FLG: hrdata_o[N_BIDIR-1:0] = fall_flg_ff;
        OFF_FUNC: hrdata_o = func_ff;
        OFF_CLKDIV: hrdata_o[DIV_WIDTH-1:0] = clkdiv_ff;
        OFF_IRQ_EN0: hrdata_o[7:0] = irq_en0_ff;
        OFF_IRQ_EN1: hrdata_o[7:0] = irq_en1_ff;
        OFF_IRQ_FLG0: hrdata_o[7:0] = irq_flg0_ff;
        OFF_IRQ_FLG1: hrdata_o[7:0] = irq_flg1_ff;
        default: hrdata_o = 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_clk_mode_held;
    (func_ff.sel == SEL_CLK) [*2];
  endsequence

  // Input pins are never driven
  chk_input_no_drive: assert property ((bidir_pin_oe_o & $past(dir_ff)) == '0)
    else $error("input pin driven");

  // Output value write stores every drive bit, input pins included
  chk_out_readback: assert property ((wr_en && dp_addr_ff == OFF_OUT) |=>
    out_ff == $past(hwdata_i[N_PIN-1:0]))
    else $error("output readback mismatch");

  // Plain output-only pin follows its stored bit
  chk_oo_drive: assert property (output_only_pin_o[3] == $past(out_ff[3]))
    else $error("output-only pin not driven from stored bit");

  // New rise flags only on input pins
  chk_edge_input: assert property ((rise_flg_ff & ~$past(rise_flg_ff) & ~$past(dir_ff)) == '0)
    else $error("rise flag set on output pin");

  // Rise flags stay set without a clearing write
  chk_flag_sticky: assert property (!(wr_en && dp_addr_ff == OFF_RISE_FLG) |=>
    (rise_flg_ff & $past(rise_flg_ff)) == $past(rise_flg_ff))
    else $error("rise flag lost without clear");

  // Write one clears when no new edge arrives
  chk_w1c_clear: assert property ((wr_en && dp_addr_ff == OFF_FALL_FLG && fall_evt == '0) |=>
    (fall_flg_ff & $past(hwdata_i[N_BIDIR-1:0])) == '0)
    else $error("fall flag not cleared by write one");

  // Pin interrupt reaches combiner group 0
  chk_pin_to_grp0: assert property (pin_irq |=> irq_flg0_ff[0])
    else $error("pin interrupt not flagged in group 0");

  // Enabled calendar event raises the combined line
  chk_cal_irq: assert property ((|(cal_evt_i & irq_en1_ff) && !wr_en) |=> combined_irq_out_o)
    else $error("calendar event did not raise combined line");

  // PWM high only inside the width
  chk_pwm_width: assert property ((pwm_st_ff == PWM_HIGH && $stable(func_ff.wexp)) |-> (pwm_cnt_ff < pwm_width))
    else $error("pwm high beyond width");

  // Filter moves only after two equal samples on a tick
  chk_filter_stable: assert property ((filt_ff != $past(filt_ff)) |->
    $past(periph_tick) && (((filt_ff ^ $past(filt_ff)) & ($past(pin_s2_ff) ^ $past(samp_ff))) == '0))
    else $error("filter accepted unstable level");

  // Clock mode drives the synced reference
  chk_clk_out: assert property (s_clk_mode_held |=> output_only_pin_o[AUX_IDX] == $past(clk32_lvl))
    else $error("pin two not carrying reference clock");

endmodule

`default_nettype wire

/* File: dv/bgp_pin_model.sv */
// Pin-side model: resolves the seven bidirectional pin wires.
// Assumes a pull-up on every pin and one external driver set by the bench.
`default_nettype none

module bgp_pin_model
  import bgp_pkg::*;
(
  // Design side
  input wire logic [N_BIDIR-1:0] drv_i,
  input wire logic [N_BIDIR-1:0] oe_i,
  // External driver
  input wire logic [N_BIDIR-1:0] ext_i,
  input wire logic ext_en_i,
  // Resolved wire level
  output logic [N_BIDIR-1:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Device drive wins, then the external driver, else the pull-up
  always_comb
  begin
    for (int i = 0; i < N_BIDIR; i++)
    begin
      level_o[i] = oe_i[i] ? drv_i[i] : (ext_en_i ? ext_i[i] : 1'b1);
    end
  end
endmodule

`default_nettype wire

/* File: dv/backup_gpio_pwm_irq_combiner_tb.sv */
// Bench for the backup pin unit: register tasks over AHB-Lite, pin and PWM checks.
// Assumes the pin model above and a free running reference at 8 core cycles.
`default_nettype none

module backup_gpio_pwm_irq_combiner_tb
  import bgp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, rst_b, hsel, hwrite, hready, hreadyout, hresp, ref32, irq, ext_en, prev;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [N_OUT-1:0] opin;
  logic [N_BIDIR-1:0] bin, bout, boe, ext;
  logic [6:0] hevt;
  logic [7:0] cevt;
  int errors, samples_checked, cycles, n, hi, lo;

  assign hready = hreadyout;

  bgp_unit uut (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .ref_32k_i(ref32), .output_only_pin_o(opin),
    .bidir_pin_i(bin), .bidir_pin_o(bout), .bidir_pin_oe_o(boe), .host_evt_i(hevt),
    .cal_evt_i(cevt), .combined_irq_out_o(irq)
  );

  bgp_pin_model pins (.drv_i(bout), .oe_i(boe), .ext_i(ext), .ext_en_i(ext_en), .level_o(bin));

  // Core clock and reference clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    ref32 = 1'b0;
    forever #20 ref32 = ~ref32;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wait_rdy;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask

  // One single transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  // Program PWM and measure one high and one low stretch in core cycles
  task automatic pwm_chk(input logic [31:0] div, input int e, input int hexp, input int lexp);
    wr(OFF_CLKDIV, div);
    wr(OFF_FUNC, (((32'd16 << e) + 32'd4) << 16) | (32'(e) << 4) | 32'h2);
    // Skip one whole period so the stretch measured runs fully under the new setting
    while (opin[2] !== 1'b0) @(posedge core_clk);
    while (opin[2] !== 1'b1) @(posedge core_clk);
    while (opin[2] !== 1'b0) @(posedge core_clk);
    while (opin[2] !== 1'b1) @(posedge core_clk);
    hi = 0;
    lo = 0;
    while (opin[2] === 1'b1)
    begin
      hi++;
      @(posedge core_clk);
    end
    while (opin[2] === 1'b0)
    begin
      lo++;
      @(posedge core_clk);
    end
    chk("pwm_high", 32'(hi), 32'(hexp));
    chk("pwm_low", 32'(lo), 32'(lexp));
  endtask

  // Hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      end_of_test();
    end
  end

  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {hevt, cevt, ext} = '0;
    ext_en = 1'b1;
    rst_b = 1'b0;
    cyc(10);
    rst_b <= 1'b1;
    cyc(1);
    // Reset values and an unmapped word
    rdc("dir", OFF_DIR, 32'h7f);
    rdc("out", OFF_OUT, 32'h0);
    rdc("clkdiv", OFF_CLKDIV, 32'h1);
    rdc("unmapped", 8'h3c, 32'h0);
    // All pins driven
    ext_en <= 1'b0;
    wr(OFF_OUT, 32'h5a5);
    wr(OFF_DIR, 32'h0);
    cyc(40);
    chk("opin", 32'(opin), 32'h5);
    chk("bout", 32'(bout), 32'h5a);
    chk("boe", 32'(boe), 32'h7f);
    rdc("in_drv", OFF_IN, 32'h5a5);
    // Pins released, OUT written while inputs
    ext <= 7'h33;
    ext_en <= 1'b1;
    wr(OFF_DIR, 32'h7f);
    wr(OFF_OUT, 32'h7ff);
    cyc(40);
    chk("boe_in", 32'(boe), 32'h0);
    chk("opin2", 32'(opin), 32'hf);
    rdc("out_rb", OFF_OUT, 32'h7ff);
    rdc("in_pin", OFF_IN, 32'h33f);
    // Rise enables only; falls still flag
    wr(OFF_RISE_FLG, 32'h7f);
    wr(OFF_FALL_FLG, 32'h7f);
    wr(OFF_RISE_EN, 32'h7f);
    wr(OFF_IRQ_EN0, 32'h1);
    ext <= 7'h0f;
    cyc(60);
    rdc("rise", OFF_RISE_FLG, 32'h0c);
    rdc("fall", OFF_FALL_FLG, 32'h30);
    chk("irq_pin", 32'(irq), 32'h1);
    wr(OFF_RISE_FLG, 32'h04);
    rdc("rise_w1", OFF_RISE_FLG, 32'h08);
    wr(OFF_RISE_FLG, 32'h0);
    rdc("rise_w0", OFF_RISE_FLG, 32'h08);
    // Fall only; rise flags cleared, then set by new rises but masked
    wr(OFF_RISE_FLG, 32'h7f);
    wr(OFF_FALL_FLG, 32'h7f);
    wr(OFF_RISE_EN, 32'h0);
    wr(OFF_FALL_EN, 32'h7f);
    wr(OFF_IRQ_FLG0, 32'h1);
    ext <= 7'h33;
    cyc(60);
    rdc("fall2", OFF_FALL_FLG, 32'h0c);
    chk("irq_fall", 32'(irq), 32'h1);
    wr(OFF_FALL_FLG, 32'h7f);
    wr(OFF_IRQ_FLG0, 32'h1);
    cyc(2);
    chk("irq_mask", 32'(irq), 32'h0);
    // Combiner sources, first with both groups masked, then each group enabled
    wr(OFF_IRQ_EN0, 32'h0);
    hevt <= 7'h01;
    cevt <= 8'h08;
    cyc(1);
    hevt <= 7'h0;
    cevt <= 8'h0;
    cyc(2);
    chk("irq_off", 32'(irq), 32'h0);
    rdc("flg0", OFF_IRQ_FLG0, 32'h02);
    rdc("flg1", OFF_IRQ_FLG1, 32'h08);
    wr(OFF_IRQ_EN1, 32'h08);
    cyc(1);
    chk("irq_g1", 32'(irq), 32'h1);
    wr(OFF_IRQ_FLG1, 32'h08);
    cyc(1);
    chk("irq_g1c", 32'(irq), 32'h0);
    cevt <= 8'h08;
    cyc(1);
    cevt <= 8'h0;
    cyc(1);
    chk("irq_cal", 32'(irq), 32'h1);
    wr(OFF_IRQ_FLG1, 32'h08);
    cyc(1);
    chk("irq_calc", 32'(irq), 32'h0);
    wr(OFF_IRQ_EN0, 32'h02);
    cyc(1);
    chk("irq_g0", 32'(irq), 32'h1);
    wr(OFF_IRQ_FLG0, 32'h02);
    cyc(1);
    chk("irq_g0c", 32'(irq), 32'h0);
    // Clock mode: aux pin follows the reference
    wr(OFF_FUNC, 32'h1);
    cyc(20);
    n = 0;
    prev = opin[2];
    repeat (80)
    begin
      @(posedge core_clk);
      if (opin[2] === 1'b1 && prev === 1'b0)
        n++;
      prev = opin[2];
    end
    chk("clk_rises", 32'(n), 32'd10);
    // PWM: one tick is 8 core cycles per divide step
    pwm_chk(32'h1, 0, 128, 32);
    pwm_chk(32'h1, 1, 256, 32);
    pwm_chk(32'h2, 0, 256, 64);
    // Back to plain output value
    wr(OFF_FUNC, 32'h0);
    wr(OFF_OUT, 32'h0);
    cyc(4);
    chk("aux_gpio", 32'(opin), 32'h0);
    // Single bit set by read-modify-write of the whole register
    wr(OFF_OUT, 32'h100);
    xfer(1'b0, OFF_OUT, 32'h0);
    wr(OFF_OUT, rd | 32'h4);
    cyc(4);
    chk("aux_rmw", 32'(opin), 32'h4);
    rdc("out_rmw", OFF_OUT, 32'h104);
    end_of_test();
  end
endmodule

`default_nettype wire
